// file: include/atso_params.svh
// constants for the atomic test-and-set and cache line maintenance block
`ifndef ATSO_PARAMS_SVH
`define ATSO_PARAMS_SVH
`define ATSO_LINE_BYTES 32
`define ATSO_LINE_LSB 5
`define ATSO_BYTE_MSB 7
`define ATSO_OP_TESTSET 3'h0
`define ATSO_OP_PREFETCH 3'h1
`define ATSO_OP_FLUSH 3'h2
`define ATSO_OP_FLUSHINV 3'h3
`define ATSO_OP_IFLUSH 3'h4
`endif

// file: include/atso_pkg.sv
// types for the atomic test-and-set and cache line maintenance block
package atso_pkg;
  typedef enum logic [2:0] {
    ATSO_TESTSET,
    ATSO_PREFETCH,
    ATSO_FLUSH,
    ATSO_FLUSHINV,
    ATSO_IFLUSH
  } atso_op_t;
endpackage : atso_pkg

// file: src/atso_rmw.sv
// test-and-set byte merge: zero test and top bit set
`timescale 1ns/10ps
`include "atso_params.svh"
module atso_rmw (
  input wire logic [7:0] rd_byte_i,
  output logic [7:0] wr_byte_o,
  output logic was_zero_o
);
  always_comb
  begin
    wr_byte_o = rd_byte_i;
    wr_byte_o[`ATSO_BYTE_MSB] = 1'b1;
    was_zero_o = (rd_byte_i == 8'h00);
  end
endmodule : atso_rmw

// file: src/atso_core.sv
// sequencer for atomic test-and-set and cache line maintenance operations
// What this block does
// - read addressed byte, test zero, write back with top bit set and other bits kept
// - condition flag set when byte was zero, cleared otherwise; nothing else changes
// - read and write form one indivisible memory transaction
// - any address except core register region; no atomic on L1 SRAM
// - L1 SRAM is never treated as atomic-capable
// - atomic accesses are always cache-inhibited, whatever the descriptor says
// - on a data cache hit, write back and invalidate before the atomic
// - interrupt before load completes aborts; operation reruns from start
// - after load completes, interrupts cannot break the sequence
// - protection faults for load and store resolved before load completes
// - prefetch fills only when line absent and l1 cacheable attribute is one
// - prefetch does nothing when line resident or cache already filling
// - line operations raise no address or protection exception
// - line size is 32 bytes for every maintenance operation
// - flush writes a dirty line back to its source memory
// - flush-invalidate writes back dirty data then invalidates the line
// - instruction-line invalidate marks the instruction line invalid
// - each maintenance operation may post-increment its pointer by one line
// - flush on dirty line writes out and marks clean; else nothing
`timescale 1ns/10ps
`include "atso_params.svh"
module atso_core #(
  parameter int ADDR_W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire atso_pkg::atso_op_t op_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic post_inc_i,
  input wire logic irq_i,
  input wire logic prot_ld_fault_i,
  input wire logic prot_st_fault_i,
  input wire logic addr_in_regs_i,
  input wire logic addr_in_l1_sram_i,
  input wire logic l1_cacheable_attr_i,
  input wire logic dc_hit_i,
  input wire logic dc_dirty_i,
  input wire logic dc_fill_busy_i,
  input wire logic dc_done_i,
  input wire logic mem_done_i,
  input wire logic [7:0] mem_rdata_i,
  output logic busy_o,
  output logic done_o,
  output logic aborted_o,
  output logic fault_o,
  output logic condition_flag_o,
  output logic flag_we_o,
  output logic [ADDR_W-1:0] next_ptr_o,
  output logic dc_fill_o,
  output logic dc_writeback_o,
  output logic dc_invalidate_o,
  output logic ic_invalidate_o,
  output logic [ADDR_W-1:0] line_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_lock_o,
  output logic mem_uncached_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o
);
  import atso_pkg::*;

  initial
  begin
    if (ADDR_W <= `ATSO_LINE_LSB)
      $error("ADDR_W too small for the line size");
  end

  typedef enum logic [2:0] {
    ATSO_IDLE,
    ATSO_CHECK,
    ATSO_CLEAN,
    ATSO_LOAD,
    ATSO_STORE,
    ATSO_LINE_WAIT,
    ATSO_FINISH
  } atso_state_t;

  atso_state_t state_r;
  atso_state_t state_nxt;
  atso_op_t op_r;
  logic [ADDR_W-1:0] addr_r;
  logic post_inc_r;
  logic [7:0] merged;
  logic was_zero;
  logic [ADDR_W-1:0] line_base;
  logic [ADDR_W-1:0] line_step;
  logic ts_illegal;

  // line base and step come from the 32-byte line size
  assign line_base = {addr_r[ADDR_W-1:`ATSO_LINE_LSB], {`ATSO_LINE_LSB{1'b0}}};
  assign line_step = ADDR_W'(`ATSO_LINE_BYTES);
  // register region, L1 SRAM and protection faults refused up front
  assign ts_illegal = addr_in_regs_i | addr_in_l1_sram_i | prot_ld_fault_i | prot_st_fault_i;

  atso_rmw u_rmw (
    .rd_byte_i(mem_rdata_i),
    .wr_byte_o(merged),
    .was_zero_o(was_zero)
  );

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ATSO_IDLE:
        if (req_i)
          state_nxt = ATSO_CHECK;
      ATSO_CHECK:
        if (op_r == ATSO_TESTSET)
        begin
          if (ts_illegal)
            state_nxt = ATSO_FINISH;
          else if (irq_i)
            state_nxt = ATSO_FINISH;
          else if (dc_hit_i)
            state_nxt = ATSO_CLEAN;
          else
            state_nxt = ATSO_LOAD;
        end
        else if (op_r == ATSO_PREFETCH)
        begin
          // resident, busy, uncacheable or faulting lines are a no-op
          if (!dc_hit_i && !dc_fill_busy_i && l1_cacheable_attr_i && !prot_ld_fault_i)
            state_nxt = ATSO_LINE_WAIT;
          else
            state_nxt = ATSO_FINISH;
        end
        else if (op_r == ATSO_IFLUSH)
          state_nxt = prot_ld_fault_i ? ATSO_FINISH : ATSO_LINE_WAIT;
        else if (dc_hit_i && !prot_ld_fault_i
                 && (dc_dirty_i || op_r == ATSO_FLUSHINV))
          state_nxt = ATSO_LINE_WAIT;
        else
          state_nxt = ATSO_FINISH;
      ATSO_CLEAN:
        if (dc_done_i)
          state_nxt = ATSO_LOAD;
        else if (irq_i)
          state_nxt = ATSO_FINISH;
      ATSO_LOAD:
        if (mem_done_i)
          state_nxt = ATSO_STORE;
        else if (irq_i)
          state_nxt = ATSO_FINISH;
      ATSO_STORE:
        if (mem_done_i)
          state_nxt = ATSO_FINISH;
      ATSO_LINE_WAIT:
        if (dc_done_i)
          state_nxt = ATSO_FINISH;
      ATSO_FINISH:
        state_nxt = ATSO_IDLE;
      default:
        state_nxt = ATSO_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      state_r <= ATSO_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      op_r <= ATSO_TESTSET;
      addr_r <= '0;
      post_inc_r <= 1'b0;
    end
    else if (state_r == ATSO_IDLE && req_i)
    begin
      op_r <= op_i;
      addr_r <= addr_i;
      post_inc_r <= post_inc_i;
    end
  end

  // test-and-set memory side; lock spans load through store
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_lock_o <= 1'b0;
      mem_uncached_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= 8'h00;
    end
    else
    begin
      mem_rd_o <= (state_nxt == ATSO_LOAD) && !(state_r == ATSO_LOAD && mem_done_i);
      mem_wr_o <= (state_nxt == ATSO_STORE);
      mem_lock_o <= (state_nxt == ATSO_LOAD) || (state_nxt == ATSO_STORE);
      mem_uncached_o <= (state_nxt == ATSO_LOAD) || (state_nxt == ATSO_STORE);
      if (state_r == ATSO_CHECK)
        mem_addr_o <= addr_r;
      if (state_r == ATSO_LOAD && mem_done_i)
        mem_wdata_o <= merged;
    end
  end

  // cache side commands held until the cache answers or an interrupt aborts the clean
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      dc_fill_o <= 1'b0;
      dc_writeback_o <= 1'b0;
      dc_invalidate_o <= 1'b0;
      ic_invalidate_o <= 1'b0;
      line_addr_o <= '0;
    end
    else
    begin
      dc_fill_o <= (state_nxt == ATSO_LINE_WAIT) && (op_r == ATSO_PREFETCH);
      dc_writeback_o <= ((state_nxt == ATSO_LINE_WAIT) && dc_dirty_r_sel(op_r))
                        || (state_nxt == ATSO_CLEAN);
      dc_invalidate_o <= ((state_nxt == ATSO_LINE_WAIT) && (op_r == ATSO_FLUSHINV))
                         || (state_nxt == ATSO_CLEAN);
      ic_invalidate_o <= (state_nxt == ATSO_LINE_WAIT) && (op_r == ATSO_IFLUSH);
      if (state_r == ATSO_CHECK)
        line_addr_o <= line_base;
    end
  end

  function automatic logic dc_dirty_r_sel(input atso_op_t op);
    dc_dirty_r_sel = (op == ATSO_FLUSH) || (op == ATSO_FLUSHINV);
  endfunction : dc_dirty_r_sel

  // completion, flag and pointer results
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      aborted_o <= 1'b0;
      fault_o <= 1'b0;
      condition_flag_o <= 1'b0;
      flag_we_o <= 1'b0;
      next_ptr_o <= '0;
    end
    else
    begin
      busy_o <= (state_nxt != ATSO_IDLE);
      done_o <= (state_nxt == ATSO_FINISH);
      flag_we_o <= 1'b0;
      if (state_r == ATSO_IDLE && req_i)
      begin
        aborted_o <= 1'b0;
        fault_o <= 1'b0;
      end
      if (state_r == ATSO_CHECK && op_r == ATSO_TESTSET && ts_illegal)
        fault_o <= 1'b1;
      if (op_r == ATSO_TESTSET && state_nxt == ATSO_FINISH && state_r != ATSO_STORE
          && state_r != ATSO_FINISH && !(state_r == ATSO_CHECK && ts_illegal))
        aborted_o <= 1'b1;
      if (state_r == ATSO_LOAD && mem_done_i)
      begin
        condition_flag_o <= was_zero;
        flag_we_o <= 1'b1;
      end
      if (state_r == ATSO_CHECK)
        next_ptr_o <= (op_r != ATSO_TESTSET && post_inc_r) ? addr_r + line_step : addr_r;
    end
  end

  lock_span_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_STORE) |-> mem_lock_o)
    else $error("lock dropped during store");
  store_after_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_LOAD && mem_done_i) |=> (state_r == ATSO_STORE))
    else $error("load completion did not lead to store");
  top_bit_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_LOAD && mem_done_i)
    |=> (mem_wdata_o == ($past(mem_rdata_i) | 8'h80)))
    else $error("write byte is not read byte with top bit set");
  flag_value_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_LOAD && mem_done_i)
    |=> (flag_we_o && condition_flag_o == ($past(mem_rdata_i) == 8'h00)))
    else $error("condition flag wrong");
  uncached_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (mem_rd_o || mem_wr_o) |-> mem_uncached_o)
    else $error("atomic access not cache-inhibited");
  clean_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_TESTSET && !ts_illegal && !irq_i && dc_hit_i)
    |=> (dc_writeback_o && dc_invalidate_o && !mem_rd_o))
    else $error("cache hit not cleaned before atomic");
  prefetch_noop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_PREFETCH && (dc_hit_i || dc_fill_busy_i))
    |=> (!dc_fill_o && state_r == ATSO_FINISH))
    else $error("prefetch started on resident line or busy cache");
  illegal_refused_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_TESTSET && addr_in_regs_i)
    |=> (!mem_rd_o && fault_o) [*1])
    else $error("test-and-set reached register region");
  sram_refused_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_TESTSET && addr_in_l1_sram_i)
    |=> (!mem_rd_o && !mem_lock_o && fault_o))
    else $error("test-and-set reached local SRAM");
  fault_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_TESTSET && (prot_ld_fault_i || prot_st_fault_i))
    |=> (!mem_rd_o && fault_o))
    else $error("protection fault not resolved before load");
  line_no_fault_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r != ATSO_TESTSET)
    |=> !fault_o)
    else $error("line operation raised a fault");
  prefetch_fill_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_PREFETCH && !dc_hit_i && !dc_fill_busy_i
     && l1_cacheable_attr_i && !prot_ld_fault_i)
    |=> (dc_fill_o && !dc_writeback_o))
    else $error("prefetch did not start a line fill");
  flush_clean_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_FLUSH && !dc_dirty_i)
    |=> (!dc_writeback_o && state_r == ATSO_FINISH))
    else $error("flush of clean line wrote back");
  flushinv_hit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_FLUSHINV && dc_hit_i && !prot_ld_fault_i)
    |=> (dc_writeback_o && dc_invalidate_o))
    else $error("flush-invalidate did not clean and drop the line");
  iline_inval_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r == ATSO_IFLUSH && !prot_ld_fault_i)
    |=> (ic_invalidate_o && !dc_invalidate_o && !dc_writeback_o))
    else $error("instruction line not invalidated");
  load_abort_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_LOAD && !mem_done_i && irq_i)
    |=> (aborted_o && !mem_wr_o && !mem_lock_o))
    else $error("interrupt before load end did not abort");
  write_locked_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    mem_wr_o |-> (mem_lock_o && !mem_rd_o))
    else $error("store issued outside the locked sequence");
  ptr_advance_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ATSO_CHECK && op_r != ATSO_TESTSET && post_inc_r)
    |=> (next_ptr_o == addr_r + line_step))
    else $error("pointer not advanced by one line");
endmodule : atso_core

// file: verif/atso_mem_model.sv
// behavioural off-core memory and data cache answering the sequencer
`timescale 1ns/10ps
module atso_mem_model #(
  parameter int DLY = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic mem_lock_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic dc_req_i,
  output logic mem_done_o,
  output logic [7:0] mem_rdata_o,
  output logic dc_done_o
);
  logic [7:0] mem [1024];
  logic [3:0] mcnt_r;
  logic [3:0] dcnt_r;
  logic [7:0] last_r;
  // one requester only, so holding the lock costs nothing here
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || mem_done_o || !(mem_rd_i || mem_wr_i))
    begin
      mcnt_r <= 4'h0;
      mem_done_o <= 1'b0;
    end
    else
    begin
      mcnt_r <= mcnt_r + 4'h1;
      mem_done_o <= (mcnt_r == DLY[3:0]);
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || dc_done_o || !dc_req_i)
    begin
      dcnt_r <= 4'h0;
      dc_done_o <= 1'b0;
    end
    else
    begin
      dcnt_r <= dcnt_r + 4'h1;
      dc_done_o <= (dcnt_r == DLY[3:0]);
    end
  end
  // data bus shows the inverse of the last byte outside a read answer
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
      last_r <= 8'h00;
    else if (mem_rd_i && mcnt_r == DLY[3:0] && !mem_done_o)
      last_r <= mem[mem_addr_i[9:0]];
    if (mem_rd_i && mcnt_r == DLY[3:0] && !mem_done_o)
      mem_rdata_o <= mem[mem_addr_i[9:0]];
    else
      mem_rdata_o <= ~last_r;
    if (mem_wr_i && mcnt_r == DLY[3:0] && !mem_done_o)
      mem[mem_addr_i[9:0]] <= mem_wdata_i;
  end
endmodule : atso_mem_model

// file: verif/atso_core_tb.sv
// self-checking bench for the test-and-set and line maintenance sequencer
`timescale 1ns/10ps
`define CHK(a, e) chk((a) === (e))
module atso_core_tb;
  import atso_pkg::*;
  typedef struct packed {
    atso_op_t op;
    logic [8:0] in;
    logic [7:0] bv;
    logic [7:0] ex;
  } atso_row_t;
  localparam int NR = 16;
  // in: hit dirty cacheable fillbusy ldflt stflt regs sram postinc
  // ex: fill wb inv ic rd wr fault cc
  atso_row_t rows [NR] = '{
    '{ATSO_PREFETCH, 9'h040, 8'h00, 8'h80}, '{ATSO_PREFETCH, 9'h001, 8'h00, 8'h00},
    '{ATSO_PREFETCH, 9'h140, 8'h00, 8'h00}, '{ATSO_PREFETCH, 9'h060, 8'h00, 8'h00},
    '{ATSO_PREFETCH, 9'h050, 8'h00, 8'h00}, '{ATSO_FLUSH, 9'h1c1, 8'h00, 8'h40},
    '{ATSO_FLUSH, 9'h140, 8'h00, 8'h00}, '{ATSO_FLUSHINV, 9'h1c0, 8'h00, 8'h60},
    '{ATSO_FLUSHINV, 9'h040, 8'h00, 8'h00}, '{ATSO_IFLUSH, 9'h001, 8'h00, 8'h10},
    '{ATSO_TESTSET, 9'h040, 8'h00, 8'h0d}, '{ATSO_TESTSET, 9'h040, 8'h35, 8'h0c},
    '{ATSO_TESTSET, 9'h1c0, 8'h7f, 8'h6c}, '{ATSO_TESTSET, 9'h004, 8'h00, 8'h02},
    '{ATSO_TESTSET, 9'h002, 8'h00, 8'h02}, '{ATSO_TESTSET, 9'h008, 8'h00, 8'h02}
  };
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  atso_op_t op_i = ATSO_TESTSET;
  logic [31:0] addr_i = 32'h0000_0000;
  logic [8:0] in_r = 9'h000;
  logic irq_i = 1'b0;
  logic busy_o, done_o, aborted_o, fault_o, condition_flag_o, flag_we_o;
  logic dc_fill_o, dc_writeback_o, dc_invalidate_o, ic_invalidate_o;
  logic mem_rd_o, mem_wr_o, mem_lock_o, mem_uncached_o, dc_done_i, mem_done_i;
  logic [31:0] next_ptr_o, line_addr_o, mem_addr_o;
  logic [7:0] mem_wdata_o, mem_rdata_i;
  logic [8:0] seen;
  logic [31:0] la;
  logic [31:0] a;
  int n_mismatch = 0;
  int checks_done = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  atso_core uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .post_inc_i(in_r[0]), .irq_i(irq_i), .prot_ld_fault_i(in_r[4]),
    .prot_st_fault_i(in_r[3]), .addr_in_regs_i(in_r[2]), .addr_in_l1_sram_i(in_r[1]),
    .l1_cacheable_attr_i(in_r[6]), .dc_hit_i(in_r[8]), .dc_dirty_i(in_r[7]),
    .dc_fill_busy_i(in_r[5]), .dc_done_i(dc_done_i), .mem_done_i(mem_done_i),
    .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o), .aborted_o(aborted_o),
    .fault_o(fault_o), .condition_flag_o(condition_flag_o), .flag_we_o(flag_we_o),
    .next_ptr_o(next_ptr_o), .dc_fill_o(dc_fill_o), .dc_writeback_o(dc_writeback_o),
    .dc_invalidate_o(dc_invalidate_o), .ic_invalidate_o(ic_invalidate_o),
    .line_addr_o(line_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_lock_o(mem_lock_o), .mem_uncached_o(mem_uncached_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o));
  atso_mem_model mdl (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .mem_rd_i(mem_rd_o),
    .mem_wr_i(mem_wr_o), .mem_lock_i(mem_lock_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_done_o(mem_done_i), .mem_rdata_o(mem_rdata_i),
    .dc_req_i(dc_fill_o | dc_writeback_o | dc_invalidate_o | ic_invalidate_o),
    .dc_done_o(dc_done_i));
  task automatic chk(input bit ok);
    checks_done++;
    if (!ok)
    begin
      n_mismatch++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // md: 1 interrupt from the start, 2 once the store is issued, 3 once the load is issued
  task automatic run(input atso_op_t op, input logic [8:0] in, input logic [1:0] md);
    seen = 9'h000;
    la = 32'h0000_0000;
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    op_i <= op;
    addr_i <= a;
    in_r <= in;
    irq_i <= (md == 2'h1);
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    for (int n = 0; n < 80 && !seen[8]; n++)
    begin
      @(posedge ref_clk_i);
      if ((md == 2'h2 && seen[2]) || (md == 2'h3 && seen[3]))
        irq_i <= 1'b1;
      @(negedge ref_clk_i);
      seen = seen | {done_o, dc_fill_o, dc_writeback_o, dc_invalidate_o, ic_invalidate_o,
        mem_rd_o, mem_wr_o, fault_o, flag_we_o};
      if (dc_fill_o | dc_writeback_o | dc_invalidate_o | ic_invalidate_o)
        la = line_addr_o;
    end
    if (!seen[8])
    begin
      chk(1'b0);
      summarize();
    end
  endtask : run
  always @(negedge ref_clk_i)
    if (!rst_i && (mem_rd_o || mem_wr_o))
      `CHK(mem_lock_o & mem_uncached_o, 1'b1);
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK({busy_o, done_o, mem_rd_o, mem_wr_o, mem_lock_o, dc_fill_o}, 6'h00);
    for (int i = 0; i < NR; i++)
    begin
      a = 32'h0000_2005 + i * 32;
      mdl.mem[a[9:0]] = rows[i].bv;
      run(rows[i].op, rows[i].in, 2'h0);
      `CHK(seen[7:1], rows[i].ex[7:1]);
      `CHK(seen[0], rows[i].ex[3]);
      `CHK(aborted_o, 1'b0);
      if (rows[i].ex[3])
      begin
        `CHK(condition_flag_o, rows[i].ex[0]);
        `CHK(mdl.mem[a[9:0]], rows[i].bv | 8'h80);
      end
      if (rows[i].ex[7:4] != 4'h0)
        `CHK(la, a & 32'hffff_ffe0);
      if (rows[i].in[0])
        `CHK(next_ptr_o, a + 32'h0000_0020);
      else
        `CHK(next_ptr_o, a);
    end
    a = 32'h0000_2305;
    mdl.mem[a[9:0]] = 8'h01;
    run(ATSO_TESTSET, 9'h040, 2'h2);
    `CHK({seen[2], aborted_o, condition_flag_o}, 3'h4);
    `CHK(mdl.mem[a[9:0]], 8'h81);
    a = 32'h0000_2325;
    mdl.mem[a[9:0]] = 8'h00;
    run(ATSO_TESTSET, 9'h040, 2'h1);
    `CHK({seen[2], aborted_o}, 2'h1);
    `CHK(mdl.mem[a[9:0]], 8'h00);
    run(ATSO_TESTSET, 9'h040, 2'h3);
    `CHK({seen[3], seen[2], seen[0], aborted_o}, 4'h9);
    `CHK(mdl.mem[a[9:0]], 8'h00);
    run(ATSO_TESTSET, 9'h040, 2'h0);
    `CHK({aborted_o, condition_flag_o}, 2'h1);
    `CHK(mdl.mem[a[9:0]], 8'h80);
    // reset in the middle of a locked load must drop the lock at once
    a = 32'h0000_2345;
    mdl.mem[a[9:0]] = 8'h00;
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    op_i <= ATSO_TESTSET;
    addr_i <= a;
    irq_i <= 1'b0;
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    `CHK({mem_rd_o, mem_lock_o}, 2'h3);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK({busy_o, mem_rd_o, mem_wr_o, mem_lock_o, mem_uncached_o, aborted_o}, 6'h00);
    run(ATSO_TESTSET, 9'h040, 2'h0);
    `CHK({condition_flag_o, mdl.mem[a[9:0]]}, 9'h180);
    summarize();
  end
endmodule : atso_core_tb
